// File: logic/pirc_apb_if.sv
// apb slave front end: decode at setup, one access cycle, no waits
// assumes a well-behaved apb master on the same clock
`timescale 1ns/1ns
`default_nettype none
module pirc_apb_if (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic [11:0]       paddr,
    output logic                   pready,
    output logic                   pslverr,
    // register side
    output logic                   setupCycle,
    output logic                   accessDone,
    output pirc_pkg::pirc_sel_e    sel
);
    pirc_pkg::pirc_bus_e state_q;
    pirc_pkg::pirc_sel_e sel_q;

    assign setupCycle = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign pready     = (state_q == pirc_pkg::BUS_ACCESS);
    assign sel        = sel_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_q <= pirc_pkg::BUS_IDLE;
        else
        begin
            case (state_q)
                pirc_pkg::BUS_IDLE:
                    if (setupCycle)
                        state_q <= pirc_pkg::BUS_ACCESS;
                default:
                    state_q <= setupCycle ? pirc_pkg::BUS_ACCESS
                                          : pirc_pkg::BUS_IDLE;
            endcase
        end
    end

    // unmapped word indices answer with an error, no side effect
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sel_q   <= pirc_pkg::SEL_NONE;
            pslverr <= 1'b0;
        end
        else if (setupCycle)
        begin
            sel_q   <= (paddr[11:10] == 2'h0) ? pirc_pkg::decode(paddr[9:2])
                                              : pirc_pkg::SEL_NONE;
            pslverr <= (pirc_pkg::decode(paddr[9:2])
                        == pirc_pkg::SEL_NONE) || (paddr[11:10] != 2'h0);
        end
        else
            pslverr <= 1'b0;
    end
endmodule
`default_nettype wire

// File: logic/pirc_evt_status.sv
// sticky event status with mask and one level interrupt
// assumes events are one-cycle pulses in the clk domain
`timescale 1ns/1ns
`default_nettype none
module pirc_evt_status #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // events and software access
    input  wire logic [W-1:0]  events,
    input  wire logic          wrStatus,
    input  wire logic          wrMask,
    input  wire logic [W-1:0]  wdata,
    // state
    output logic [W-1:0]       status,
    output logic [W-1:0]       mask,
    output logic               irq
);
    // write one clears; a same-cycle event keeps the bit set
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            status <= '0;
        else
            status <= (status & ~(wrStatus ? wdata : '0)) | events;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mask <= '0;
        else if (wrMask)
            mask <= wdata;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end
endmodule
`default_nettype wire

// File: logic/pirc_params.svh
// constants for the peripheral irq / reset cause register bank
// assumes an apb slave with word-aligned register indices
`ifndef PIRC_PARAMS_SVH
`define PIRC_PARAMS_SVH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PIRC_IDX_FLAGS   8'h0C
`define PIRC_IDX_ENABLES 8'h8C
`define PIRC_IDX_CAUSE   8'h8E
`define PIRC_IDX_TRIM    8'h90
`define PIRC_IDX_STATUS  8'hA0
`define PIRC_IDX_MASK    8'hA1
// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define PIRC_BIT_MEMWR   3'h7
`define PIRC_BIT_CONV    3'h6
`define PIRC_BIT_CMP     3'h3
`define PIRC_BIT_TMRB    3'h0
`define PIRC_IRQ_MASK    8'hC9
`define PIRC_BIT_POR     1'h1
`define PIRC_BIT_BOD     1'h0
`define PIRC_CAUSE_MASK  8'h03
`define PIRC_TRIM_LSB    2'h2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIRC_RST_BYTE    8'h00
`define PIRC_RST_TRIM    6'h20
`endif

// File: logic/pirc_pkg.sv
// types shared by the register bank and its bus front end
// assumes pirc_params.svh is on the include path
`default_nettype none
`include "pirc_params.svh"
package pirc_pkg;
    typedef enum {
        SEL_NONE,
        SEL_FLAGS,
        SEL_ENABLES,
        SEL_CAUSE,
        SEL_TRIM,
        SEL_STATUS,
        SEL_MASK
    } pirc_sel_e;
    typedef enum {
        BUS_IDLE,
        BUS_ACCESS
    } pirc_bus_e;
    typedef logic [7:0] pirc_byte_t;

    // word index to register select
    function automatic pirc_sel_e decode(input logic [7:0] idx);
        pirc_sel_e s;
        s = SEL_NONE;
        if (idx == `PIRC_IDX_FLAGS)
            s = SEL_FLAGS;
        else if (idx == `PIRC_IDX_ENABLES)
            s = SEL_ENABLES;
        else if (idx == `PIRC_IDX_CAUSE)
            s = SEL_CAUSE;
        else if (idx == `PIRC_IDX_TRIM)
            s = SEL_TRIM;
        else if (idx == `PIRC_IDX_STATUS)
            s = SEL_STATUS;
        else if (idx == `PIRC_IDX_MASK)
            s = SEL_MASK;
        return s;
    endfunction
endpackage
`default_nettype wire

// File: logic/pirc_regs.sv
// peripheral irq enables/flags, reset cause and oscillator trim
// assumes: reset is the power-on reset; warm resets arrive as pulses
//
// Our own choice: the APB register port.
`include "pirc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pirc_regs (
    // clock and power-on reset
    input  wire logic         clk,
    input  wire logic         reset,
    // apb
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // peripheral events, one-cycle pulses
    input  wire logic         memWriteDone,
    input  wire logic         conversionDone,
    input  wire logic         comparatorChange,
    input  wire logic         timerBOverflow,
    // warm resets and core gate
    input  wire logic         brownoutDetect,
    input  wire logic         warmReset,
    input  wire logic         peripheral_irq_gate,
    // outputs
    output logic              periphIrqReq,
    output logic [5:0]        trimCode,
    output logic              irq
);
    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    logic                setupCycle;
    logic                accessDone;
    pirc_pkg::pirc_sel_e sel;
    logic                wrFire;
    pirc_pkg::pirc_byte_t wbyte;

    pirc_apb_if u_apb (
        .clk        (clk),
        .reset      (reset),
        .psel       (psel),
        .penable    (penable),
        .paddr      (paddr),
        .pready     (pready),
        .pslverr    (pslverr),
        .setupCycle (setupCycle),
        .accessDone (accessDone),
        .sel        (sel)
    );

    // only byte lane 0 carries data; other lanes are ignored
    assign wrFire = accessDone && pwrite && pstrb[0];
    assign wbyte  = pwdata[7:0];

    function automatic logic wr(input pirc_pkg::pirc_sel_e s,
                                input pirc_pkg::pirc_sel_e r,
                                input logic f);
        return f && (s == r);
    endfunction

    // ----------------------------------------------------------------
    // events and warm resets
    // ----------------------------------------------------------------
    pirc_pkg::pirc_byte_t evVec;
    logic                 softClr;

    always_comb
    begin
        evVec                 = `PIRC_RST_BYTE;
        evVec[`PIRC_BIT_MEMWR] = memWriteDone;
        evVec[`PIRC_BIT_CONV]  = conversionDone;
        evVec[`PIRC_BIT_CMP]   = comparatorChange;
        evVec[`PIRC_BIT_TMRB]  = timerBOverflow;
    end

    // brown-out and warm resets restore enables, flags and trim; brown-out also clears the bod cause bit
    assign softClr = brownoutDetect || warmReset;

    // ----------------------------------------------------------------
    // peripheral enables and flags
    // ----------------------------------------------------------------
    pirc_pkg::pirc_byte_t enables_q;
    pirc_pkg::pirc_byte_t flags_q;
    pirc_pkg::pirc_byte_t flags_d;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            enables_q <= `PIRC_RST_BYTE;
        else if (softClr)
            enables_q <= `PIRC_RST_BYTE;
        else if (wr(sel, pirc_pkg::SEL_ENABLES, wrFire))
            enables_q <= wbyte & `PIRC_IRQ_MASK;
    end

    // event wins over a software clear in the same cycle
    always_comb
    begin
        flags_d = flags_q;
        if (wr(sel, pirc_pkg::SEL_FLAGS, wrFire))
            flags_d = wbyte;
        flags_d = (flags_d | evVec) & `PIRC_IRQ_MASK;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            flags_q <= `PIRC_RST_BYTE;
        else if (softClr)
            flags_q <= `PIRC_RST_BYTE;
        else
            flags_q <= flags_d;
    end

    // gate comes from the core's interrupt control register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            periphIrqReq <= 1'b0;
        else
            periphIrqReq <= peripheral_irq_gate
                            && |(flags_q & enables_q);
    end

    // ----------------------------------------------------------------
    // reset cause
    // ----------------------------------------------------------------
    logic porBit_q;
    logic bodBit_q;

    // only the power-on reset or a cause write clears this bit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            porBit_q <= 1'b0;
        else if (wr(sel, pirc_pkg::SEL_CAUSE, wrFire))
            porBit_q <= wbyte[`PIRC_BIT_POR];
    end

    // level at power-on is undefined in silicon; zero chosen here
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            bodBit_q <= 1'b0;
        else if (brownoutDetect)
            bodBit_q <= 1'b0;
        else if (wr(sel, pirc_pkg::SEL_CAUSE, wrFire))
            bodBit_q <= wbyte[`PIRC_BIT_BOD];
    end

    // ----------------------------------------------------------------
    // oscillator trim
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            trimCode <= `PIRC_RST_TRIM;
        else if (softClr)
            trimCode <= `PIRC_RST_TRIM;
        else if (wr(sel, pirc_pkg::SEL_TRIM, wrFire))
            trimCode <= wbyte[7:`PIRC_TRIM_LSB];
    end

    // ----------------------------------------------------------------
    // event status and interrupt
    // ----------------------------------------------------------------
    pirc_pkg::pirc_byte_t status;
    pirc_pkg::pirc_byte_t mask;

    pirc_evt_status #(
        .W (8)
    ) u_evt (
        .clk      (clk),
        .reset    (reset),
        .events   (evVec),
        .wrStatus (wr(sel, pirc_pkg::SEL_STATUS, wrFire)),
        .wrMask   (wr(sel, pirc_pkg::SEL_MASK, wrFire)),
        .wdata    (wbyte),
        .status   (status),
        .mask     (mask),
        .irq      (irq)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    pirc_pkg::pirc_byte_t rdByte;
    pirc_pkg::pirc_sel_e  rdSel;

    // upper address bits out of range read as unmapped, data zero
    assign rdSel = (paddr[11:10] == 2'h0) ? pirc_pkg::decode(paddr[9:2])
                                          : pirc_pkg::SEL_NONE;

    always_comb
    begin
        rdByte = `PIRC_RST_BYTE;
        if (rdSel == pirc_pkg::SEL_FLAGS)
            rdByte = flags_q;
        else if (rdSel == pirc_pkg::SEL_ENABLES)
            rdByte = enables_q;
        else if (rdSel == pirc_pkg::SEL_CAUSE)
        begin
            rdByte[`PIRC_BIT_POR] = porBit_q;
            rdByte[`PIRC_BIT_BOD] = bodBit_q;
        end
        else if (rdSel == pirc_pkg::SEL_TRIM)
            rdByte[7:`PIRC_TRIM_LSB] = trimCode;
        else if (rdSel == pirc_pkg::SEL_STATUS)
            rdByte = status;
        else if (rdSel == pirc_pkg::SEL_MASK)
            rdByte = mask;
    end

    // data captured at setup, stands through the access cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (setupCycle && !pwrite)
            prdata <= {24'h00_0000, rdByte};
        else if (!psel)
            prdata <= 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_enable_unused: assert property (
        (enables_q & ~`PIRC_IRQ_MASK) == 8'h00)
        else $error("enable register holds an unimplemented bit");

    chk_flag_unused: assert property (
        (flags_q & ~`PIRC_IRQ_MASK) == 8'h00)
        else $error("flag register holds an unimplemented bit");

    chk_flag_event_set: assert property (
        (conversionDone && !softClr) |=> flags_q[`PIRC_BIT_CONV])
        else $error("conversion event did not set its flag");

    chk_flag_sticky: assert property (
        (flags_q[`PIRC_BIT_CMP] && !softClr
         && !wr(sel, pirc_pkg::SEL_FLAGS, wrFire))
        |=> flags_q[`PIRC_BIT_CMP])
        else $error("comparator flag dropped without a write");

    chk_req_gate: assert property (
        periphIrqReq |-> $past(peripheral_irq_gate)
        && ($past(flags_q) & $past(enables_q)) != 8'h00)
        else $error("peripheral request raised without its cause");

    chk_cause_read: assert property (
        (setupCycle && !pwrite && rdSel == pirc_pkg::SEL_CAUSE)
        |=> (prdata[7:0] & ~`PIRC_CAUSE_MASK) == 8'h00
        && prdata[1] == $past(porBit_q))
        else $error("reset cause readback wrong");

    chk_por_kept: assert property (
        (warmReset && !wr(sel, pirc_pkg::SEL_CAUSE, wrFire))
        |=> porBit_q == $past(porBit_q))
        else $error("warm reset changed the power-on bit");

    chk_bod_clear: assert property (
        brownoutDetect |=> !bodBit_q ##1 (!bodBit_q ||
        $past(wr(sel, pirc_pkg::SEL_CAUSE, wrFire))))
        else $error("brown-out bit not cleared on brown-out");

    chk_trim_write: assert property (
        (wr(sel, pirc_pkg::SEL_TRIM, wrFire) && !softClr)
        |=> trimCode == $past(pwdata[7:2]))
        else $error("trim write not applied");

    chk_trim_reset: assert property (
        softClr |=> trimCode == `PIRC_RST_TRIM)
        else $error("trim code not restored to centre");

    chk_cause_addr: assert property (
        (setupCycle && paddr[9:2] == `PIRC_IDX_CAUSE
         && paddr[11:10] == 2'h0)
        |=> sel == pirc_pkg::SEL_CAUSE && !pslverr)
        else $error("reset cause index not decoded");

    chk_enable_write: assert property (
        (wr(sel, pirc_pkg::SEL_ENABLES, wrFire) && !softClr)
        |=> enables_q == ($past(wbyte) & `PIRC_IRQ_MASK))
        else $error("enable write not applied");

    chk_enable_read: assert property (
        (setupCycle && !pwrite && rdSel == pirc_pkg::SEL_ENABLES)
        |=> prdata == {24'h00_0000, $past(enables_q)})
        else $error("enable readback wrong");

    chk_flag_read: assert property (
        (setupCycle && !pwrite && rdSel == pirc_pkg::SEL_FLAGS)
        |=> prdata == {24'h00_0000, $past(flags_q)})
        else $error("flag readback wrong");

    chk_flag_any_event: assert property (
        (evVec != `PIRC_RST_BYTE && !softClr)
        |=> (flags_q & $past(evVec)) == $past(evVec))
        else $error("peripheral event did not set its flag");

    chk_flag_write: assert property (
        (wr(sel, pirc_pkg::SEL_FLAGS, wrFire) && !softClr)
        |=> flags_q == (($past(wbyte) | $past(evVec)) & `PIRC_IRQ_MASK))
        else $error("flag write not applied");

    chk_req_raise: assert property (
        (peripheral_irq_gate && (flags_q & enables_q) != 8'h00)
        |=> periphIrqReq)
        else $error("peripheral request missing");

    chk_cause_write: assert property (
        (wr(sel, pirc_pkg::SEL_CAUSE, wrFire) && !brownoutDetect)
        |=> porBit_q == $past(wbyte[`PIRC_BIT_POR])
        && bodBit_q == $past(wbyte[`PIRC_BIT_BOD]))
        else $error("reset cause write not applied");

    chk_trim_read: assert property (
        (setupCycle && !pwrite && rdSel == pirc_pkg::SEL_TRIM)
        |=> prdata == {24'h00_0000, $past(trimCode), 2'h0})
        else $error("trim readback wrong");
endmodule
`default_nettype wire

// File: verif/pirc_regs_tb.sv
// self-checking bench for the peripheral irq / reset cause register bank
// assumes pirc_pkg and pirc_params.svh are compiled and on the include path
`include "pirc_params.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module pirc_regs_tb;
    // ------------------------------------------------------------
    // byte addresses: word index times four
    // ------------------------------------------------------------
    localparam logic [11:0] aFlags = {2'b00, `PIRC_IDX_FLAGS, 2'b00};
    localparam logic [11:0] aEna   = {2'b00, `PIRC_IDX_ENABLES, 2'b00};
    localparam logic [11:0] aCause = {2'b00, `PIRC_IDX_CAUSE, 2'b00};
    localparam logic [11:0] aTrim  = {2'b00, `PIRC_IDX_TRIM, 2'b00};
    localparam logic [11:0] aSts   = {2'b00, `PIRC_IDX_STATUS, 2'b00};
    localparam logic [11:0] aMsk   = {2'b00, `PIRC_IDX_MASK, 2'b00};
    localparam logic [7:0]  fBit [0:3] = '{8'h01, 8'h08, 8'h40, 8'h80};
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb, ev;
    logic        brownoutDetect, warmReset, gate, periphIrqReq, irq, e;
    logic [5:0]  trimCode;
    int          n_errors, checked, cycles;

    pirc_regs pirc_regs_inst (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memWriteDone(ev[3]), .conversionDone(ev[2]),
        .comparatorChange(ev[1]), .timerBOverflow(ev[0]),
        .brownoutDetect(brownoutDetect), .warmReset(warmReset),
        .peripheral_irq_gate(gate), .periphIrqReq(periphIrqReq),
        .trimCode(trimCode), .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // bus and helper tasks
    // ------------------------------------------------------------
    // entered just after a rising edge; leaves one idle edge behind
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= {24'h000000, d}; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1, r, e);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00, 4'h0, r, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        rd(aFlags); `CHK("flags", 32'h00, r)
        rd(aEna);   `CHK("enables", 32'h00, r)
        rd(aCause); `CHK("cause", 32'h00, r)
        rd(aTrim);  `CHK("trim", 32'h80, r)
        `CHK("trimCode", 6'h20, trimCode)
        $display("done reset values");
    endtask

    task automatic t_layout;
        wr(aEna, 8'hFF);   rd(aEna);   `CHK("enables", 32'hC9, r)
        wr(aFlags, 8'hFF); rd(aFlags); `CHK("flags", 32'hC9, r)
        cyc(2); `CHK("req gate off", 1'b0, periphIrqReq)
        wr(aFlags, 8'h00); rd(aFlags); `CHK("flags", 32'h00, r)
        wr(aEna, 8'h00);
        wr(aCause, 8'hFF); rd(aCause); `CHK("cause", 32'h03, r)
        wr(aTrim, 8'hFF);  rd(aTrim);  `CHK("trim", 32'hFC, r)
        `CHK("trimCode max", 6'h3F, trimCode)
        wr(aTrim, 8'h03);  `CHK("trimCode min", 6'h00, trimCode)
        $display("done bit layout");
    endtask

    task automatic t_events;
        gate <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ev[i] <= 1'b1;
            @(posedge clk);
            ev <= 4'h0;
            cyc(3);
            `CHK("req no enable", 1'b0, periphIrqReq)
            rd(aFlags); `CHK("flag set", {24'h0, fBit[i]}, r)
            wr(aEna, fBit[i]); cyc(2);
            `CHK("req on", 1'b1, periphIrqReq)
            gate <= 1'b0; cyc(3);
            `CHK("req gated", 1'b0, periphIrqReq)
            gate <= 1'b1; cyc(3);
            rd(aFlags); `CHK("flag held", {24'h0, fBit[i]}, r)
            wr(aFlags, 8'h00); cyc(2);
            `CHK("req cleared", 1'b0, periphIrqReq)
            wr(aEna, 8'h00);
        end
        ev[2] <= 1'b1; @(posedge clk); ev <= 4'h0; cyc(2);
        wr(aFlags, 8'h00);
        wr(aEna, 8'h40); cyc(2);
        `CHK("req stale cleared", 1'b0, periphIrqReq)
        wr(aEna, 8'h00);
        $display("done events");
    endtask

    task automatic t_irq;
        rd(aSts); `CHK("status", 32'hC9, r)
        cyc(2); `CHK("irq masked", 1'b0, irq)
        wr(aMsk, 8'h08); cyc(2); `CHK("irq", 1'b1, irq)
        wr(aSts, 8'h08); cyc(2); `CHK("irq cleared", 1'b0, irq)
        rd(aSts); `CHK("status w1c", 32'hC1, r)
        wr(aSts, 8'hC1); rd(aSts); `CHK("status", 32'h00, r)
        rd(aMsk); `CHK("mask", 32'h08, r)
        wr(aMsk, 8'h00);
        $display("done interrupt");
    endtask

    task automatic t_resets;
        wr(aCause, 8'h03); wr(aEna, 8'hC9); wr(aTrim, 8'h00);
        warmReset <= 1'b1; @(posedge clk); warmReset <= 1'b0; cyc(2);
        rd(aCause); `CHK("cause warm", 32'h03, r)
        rd(aEna); `CHK("enables warm", 32'h00, r)
        `CHK("trimCode warm", 6'h20, trimCode)
        brownoutDetect <= 1'b1; @(posedge clk); brownoutDetect <= 1'b0;
        cyc(2);
        rd(aCause); `CHK("cause brownout", 32'h02, r)
        wr(aCause, 8'h03); rd(aCause); `CHK("cause set", 32'h03, r)
        wr(aTrim, 8'h00);
        reset <= 1'b1; cyc(3); reset <= 1'b0; @(posedge clk);
        rd(aCause); `CHK("cause por", 32'h00, r)
        `CHK("trimCode por", 6'h20, trimCode)
        $display("done resets");
    endtask

    task automatic t_refuse;
        apb(1'b1, 12'h100, 8'hFF, 4'h1, r, e); `CHK("err wr", 1'b1, e)
        apb(1'b0, 12'h100, 8'h00, 4'h0, r, e); `CHK("err rd", 1'b1, e)
        `CHK("unmapped data", 32'h00, r)
        apb(1'b0, 12'hC30, 8'h00, 4'h0, r, e); `CHK("err high", 1'b1, e)
        `CHK("high data", 32'h00, r)
        apb(1'b1, 12'hC30, 8'hFF, 4'h1, r, e); `CHK("err high wr", 1'b1, e)
        rd(aFlags); `CHK("high write ignored", 32'h00, r)
        apb(1'b1, aEna, 8'hFF, 4'h0, r, e); `CHK("no err", 1'b0, e)
        rd(aEna); `CHK("strobe off", 32'h00, r)
        $display("done refusals");
    endtask

    // ------------------------------------------------------------
    // closing, timeout and main sequence
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; ev = 4'h0;
        brownoutDetect = 1'b0; warmReset = 1'b0; gate = 1'b0;
        n_errors = 0; checked = 0; cycles = 0;
        repeat (20) @(posedge clk);
        `CHK("trimCode in reset", 6'h20, trimCode)
        reset <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_layout();
        t_events();
        t_irq();
        t_refuse();
        t_resets();
        report_and_stop();
    end
endmodule
`default_nettype wire
